// ### shared/pcecap_defines.vh
/*
  Constants for the vendor-specific configuration capability block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PCECAP_DEFINES_VH
`define PCECAP_DEFINES_VH
`define PCECAP_CAP_PTR 8'h40
`define PCECAP_CAP_ID 8'h09
`define PCECAP_CAP_LEN 8'h40
`define PCECAP_CAP_NEXT 8'h00
`define PCECAP_OFF_HDR 8'h00
`define PCECAP_OFF_MAP0 8'h04
`define PCECAP_OFF_MAP5 8'h18
`define PCECAP_OFF_SPACE 8'h1c
`define PCECAP_OFF_BUSCFG 8'h20
`define PCECAP_OFF_MASK0 8'h24
`define PCECAP_OFF_MASK5 8'h38
`define PCECAP_OFF_BURST 8'h3c
`define PCECAP_OFF_CAPPTR 8'h34
`define PCECAP_NUM_BARS 6
`define PCECAP_BAR_NONE 3'h6
`define PCECAP_BIT_ENDIAN 0
`define PCECAP_BIT_DISCARD_TIMEOUT_ENABLE 1
`define PCECAP_BIT_PF 3
`define PCECAP_BIT_BAREN 31
`define PCECAP_BURST_RST 16'hffff
`define PCECAP_MASK_RST 28'h0000000
`define PCECAP_SPACE_MASK 32'hffffff00
`define PCECAP_MASKREG_MASK 32'hfffffff8
`define PCECAP_IO_MASK 32'hfff00000
`define PCECAP_DISCARD_CYCLES 16'h8000
`define PCECAP_SZ_BYTE 2'h0
`define PCECAP_SZ_HALF 2'h1
`define PCECAP_SZ_WORD 2'h2
`define PCECAP_BE_NONE 4'hf
`endif

// ### hw/pcecap_core.v
/*
  Vendor-specific extended configuration capability: header, BAR to AHB
  mapping, space mapping, bus config, BAR size masks, burst limit, plus
  byte-enable mapping, lane swap and delayed-access discard timer.
  Assumes a config port already decoded to this capability, synchronous
  to core_clk, and datapath logic elsewhere that consumes the outputs.
*/
// Behaviour
// - Header reads ID 0x09, length 0x40, next pointer zero; read only.
// - Registers decoded at offsets 0x00..0x3c from the capability pointer.
// - Standard header capability pointer reports 0x40.
// - Six writable BAR-to-AHB maps; bits outside BAR size read zero.
// - Space map bits 31:8 writable, bits 7:0 read zero.
// - I/O base read only in bits 31:20; bits 19:2 read zero.
// - Discard enable drops pending delayed access after 2**15 cycles; resets zero.
// - Endian switch: one means PCI little-endian, zero big-endian; resets zero.
// - BAR bits 31:4 implemented exactly when their size mask bit is set; map bits 3:0 read zero.
// - BAR disabled when size mask bit 31 is zero.
// - Size mask bit 3 gives prefetchable flag; bits 2:0 read zero.
// - Burst limit bits 15:0 are beats minus one; reset 0xffff.
// - Single and burst transfers supported on both sides.
// - Independent FIFOs exist for each of the six data paths.
// - Byte transfers map to one-cold enables, reversed for big-endian.
// - Halfword and word enables per table; other combinations unsupported.
// - Lanes swapped when PCI little-endian, passed when big-endian.
`timescale 1ns/1ns
`include "pcecap_defines.vh"
module pcecap_core #(
  parameter [31:0] IO_BASE = 32'hfff00000
) (
  input wire core_clk,
  input wire reset_n,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgWData,
  output reg [31:0] cfgRData_q,
  output reg [7:0] capPtr_q,
  output reg endianLittle_q,
  output reg discardTimeoutEnable_q,
  output reg [15:0] burstLimit_q,
  output reg [`PCECAP_NUM_BARS-1:0] barEnable_q,
  output reg [`PCECAP_NUM_BARS-1:0] prefetchableFlag_q,
  output reg [32*`PCECAP_NUM_BARS-1:0] barMap_q,
  output reg [32*`PCECAP_NUM_BARS-1:0] barMask_q,
  output reg [31:0] spaceMap_q,
  input wire [1:0] ahbSize,
  input wire [1:0] ahbAddrLow,
  output reg [3:0] pciByteEnN_q,
  output reg sizeError_q,
  input wire [31:0] ahbData,
  output reg [31:0] pciData_q,
  input wire delayedPending,
  input wire delayedRetry,
  output reg delayedDiscard_q
);

  reg [31:0] mapReg [0:`PCECAP_NUM_BARS-1];
  reg [31:0] maskReg [0:`PCECAP_NUM_BARS-1];
  reg [31:0] spaceReg;
  reg [1:0] cfgBits;
  reg [15:0] burstReg;
  reg [15:0] discardCnt;
  reg [31:0] rdata;
  reg [3:0] beN;
  reg beBad;
  integer i;

  // Index of a BAR-indexed register at base, or NUM_BARS when not in range
  function [2:0] barIndex;
    input [7:0] addr;
    input [7:0] base;
    reg [7:0] diff;
    begin
      diff = addr - base;
      if (addr >= base && diff[7:2] < `PCECAP_NUM_BARS && diff[1:0] == 2'h0) begin
        barIndex = diff[4:2];
      end else begin
        barIndex = `PCECAP_BAR_NONE;
      end
    end
  endfunction

  wire [2:0] mapIdx = barIndex(cfgAddr, `PCECAP_OFF_MAP0);
  wire [2:0] maskIdx = barIndex(cfgAddr, `PCECAP_OFF_MASK0);

  // Register writes; read-only and reserved bits have no storage, except map bit 3, which keeps written data while size mask bit 3 is set
  always @(posedge core_clk) begin
    if (!reset_n) begin
      for (i = 0; i < `PCECAP_NUM_BARS; i = i + 1) begin
        mapReg[i] <= 32'h00000000;
        maskReg[i] <= 32'h00000000;
      end
      spaceReg <= 32'h00000000;
      cfgBits <= 2'h0;
      burstReg <= `PCECAP_BURST_RST;
    end else if (cfgWrite) begin
      if (mapIdx != `PCECAP_NUM_BARS) begin
        mapReg[mapIdx] <= cfgWData & maskReg[mapIdx];
      end else if (cfgAddr == `PCECAP_OFF_SPACE) begin
        spaceReg <= cfgWData & `PCECAP_SPACE_MASK;
      end else if (cfgAddr == `PCECAP_OFF_BUSCFG) begin
        cfgBits <= cfgWData[1:0];
      end else if (maskIdx != `PCECAP_NUM_BARS) begin
        maskReg[maskIdx] <= cfgWData & `PCECAP_MASKREG_MASK;
        // Shrinking a BAR clears map bits it no longer covers
        mapReg[maskIdx] <= mapReg[maskIdx] & (cfgWData & `PCECAP_MASKREG_MASK);
      end else if (cfgAddr == `PCECAP_OFF_BURST) begin
        burstReg <= cfgWData[15:0];
      end
    end
  end

  // Read mux
  always @* begin
    rdata = 32'h00000000;
    if (cfgAddr == `PCECAP_OFF_HDR) begin
      rdata = {8'h00, `PCECAP_CAP_LEN, `PCECAP_CAP_NEXT, `PCECAP_CAP_ID};
    end else if (mapIdx != `PCECAP_NUM_BARS) begin
      rdata = mapReg[mapIdx] & {maskReg[mapIdx][31:4], 4'h0};
    end else if (cfgAddr == `PCECAP_OFF_SPACE) begin
      rdata = spaceReg;
    end else if (cfgAddr == `PCECAP_OFF_BUSCFG) begin
      rdata = (IO_BASE & `PCECAP_IO_MASK) | {30'h0, cfgBits};
    end else if (maskIdx != `PCECAP_NUM_BARS) begin
      rdata = maskReg[maskIdx];
    end else if (cfgAddr == `PCECAP_OFF_BURST) begin
      rdata = {16'h0000, burstReg};
    end
  end

  // Byte enable table, active low
  always @* begin
    beN = `PCECAP_BE_NONE;
    beBad = 1'b0;
    case (ahbSize)
      `PCECAP_SZ_BYTE: begin
        beN = 4'hf ^ (4'h1 << ahbAddrLow);
        if (!endianLittle_q) begin
          beN = {beN[0], beN[1], beN[2], beN[3]};
        end
      end
      `PCECAP_SZ_HALF: begin
        if (ahbAddrLow == 2'h0) begin
          beN = endianLittle_q ? 4'hc : 4'h3;
        end else if (ahbAddrLow == 2'h2) begin
          beN = endianLittle_q ? 4'h3 : 4'hc;
        end else begin
          beBad = 1'b1;
        end
      end
      `PCECAP_SZ_WORD: begin
        if (ahbAddrLow == 2'h0) begin
          beN = 4'h0;
        end else begin
          beBad = 1'b1;
        end
      end
      default: begin
        beBad = 1'b1;
      end
    endcase
  end

  // Registered outputs
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cfgRData_q <= 32'h00000000;
      capPtr_q <= 8'h00;
      endianLittle_q <= 1'b0;
      discardTimeoutEnable_q <= 1'b0;
      burstLimit_q <= `PCECAP_BURST_RST;
      spaceMap_q <= 32'h00000000;
      pciByteEnN_q <= `PCECAP_BE_NONE;
      sizeError_q <= 1'b0;
      pciData_q <= 32'h00000000;
    end else begin
      cfgRData_q <= cfgRead ? rdata : 32'h00000000;
      capPtr_q <= `PCECAP_CAP_PTR;
      endianLittle_q <= cfgBits[`PCECAP_BIT_ENDIAN];
      discardTimeoutEnable_q <= cfgBits[`PCECAP_BIT_DISCARD_TIMEOUT_ENABLE];
      burstLimit_q <= burstReg;
      spaceMap_q <= spaceReg;
      pciByteEnN_q <= beN;
      sizeError_q <= beBad;
      // AHB is big-endian; swap only toward a little-endian PCI bus
      // Each beat passes alone, so single and burst beats look the same
      // The six path FIFOs sit outside; nothing here is shared between paths
      pciData_q <= endianLittle_q ?
        {ahbData[7:0], ahbData[15:8], ahbData[23:16], ahbData[31:24]} : ahbData;
    end
  end

  // Per-BAR outputs, one register set per BAR
  genvar g;
  generate
    for (g = 0; g < `PCECAP_NUM_BARS; g = g + 1) begin : gBarOut
      always @(posedge core_clk) begin
        if (!reset_n) begin
          barEnable_q[g] <= 1'b0;
          prefetchableFlag_q[g] <= 1'b0;
          barMap_q[32*g +: 32] <= 32'h00000000;
          barMask_q[32*g +: 32] <= 32'h00000000;
        end else begin
          barEnable_q[g] <= maskReg[g][`PCECAP_BIT_BAREN];
          prefetchableFlag_q[g] <= maskReg[g][`PCECAP_BIT_PF];
          barMap_q[32*g +: 32] <= mapReg[g] & {maskReg[g][31:4], 4'h0};
          barMask_q[32*g +: 32] <= maskReg[g];
        end
      end
    end
  endgenerate

  // Delayed-access discard timer
  always @(posedge core_clk) begin
    if (!reset_n) begin
      discardCnt <= 16'h0000;
      delayedDiscard_q <= 1'b0;
    end else begin
      delayedDiscard_q <= 1'b0;
      if (!delayedPending || delayedRetry || !discardTimeoutEnable_q) begin
        discardCnt <= 16'h0000;
      end else if (discardCnt == `PCECAP_DISCARD_CYCLES - 16'h0001) begin
        discardCnt <= 16'h0000;
        delayedDiscard_q <= 1'b1;
      end else begin
        discardCnt <= discardCnt + 16'h0001;
      end
    end
  end

endmodule

// ### bench/pcecap_checker_assertions.sv
/* Timing checks on the capability block ports.
   Assumes one clock and a sync active-low reset; bound from the bench. */
`timescale 1ns/1ns
module pcecap_checker (
  input wire core_clk,
  input wire reset_n,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgWData,
  input wire [31:0] cfgRData_q,
  input wire [7:0] capPtr_q,
  input wire endianLittle_q,
  input wire [15:0] burstLimit_q,
  input wire [1:0] ahbSize,
  input wire [1:0] ahbAddrLow,
  input wire [3:0] pciByteEnN_q,
  input wire [31:0] ahbData,
  input wire [31:0] pciData_q
);
  wire [31:0] swapped = {ahbData[7:0], ahbData[15:8], ahbData[23:16], ahbData[31:24]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  cap_ptr_a: assert property ($past(reset_n) |-> capPtr_q == 8'h40)
    else $error("capability pointer wrong");
  hdr_read_a: assert property (cfgRead && cfgAddr == 8'h00 |=> cfgRData_q == 32'h00400009)
    else $error("header read wrong");
  burst_reset_a: assert property (!$past(reset_n) |-> burstLimit_q == 16'hffff)
    else $error("burst limit reset wrong");
  endian_follow_a: assert property (cfgWrite && cfgAddr == 8'h20 |->
    ##3 endianLittle_q == $past(cfgWData[0], 3)) else $error("endian switch wrong");
  byte_lane_a: assert property (ahbSize == 2'h0 |=> pciByteEnN_q == ($past(endianLittle_q) ?
    ~(4'h1 << $past(ahbAddrLow)) : ~(4'h8 >> $past(ahbAddrLow)))) else $error("byte enable wrong");
  word_be_a: assert property (ahbSize == 2'h2 && ahbAddrLow == 2'h0 |=> pciByteEnN_q == 4'h0)
    else $error("word enable wrong");
  lane_swap_a: assert property (1'b1 |=>
    pciData_q == ($past(endianLittle_q) ? $past(swapped) : $past(ahbData))) else $error("lanes wrong");
  space_low_a: assert property (cfgRead && cfgAddr == 8'h1c |=> cfgRData_q[7:0] == 8'h00)
    else $error("space map low bits set");
  io_rsvd_a: assert property (cfgRead && cfgAddr == 8'h20 |=> cfgRData_q[19:2] == 18'h0)
    else $error("bus config reserved bits set");
endmodule

// ### bench/pcecap_agent.sv
/* Target-side agent that holds a delayed access open.
   Assumes the bench picks the mode: 0 idle, 1 never retry, 2 retry often. */
`timescale 1ns/1ns
module pcecap_agent (
  input wire core_clk,
  input wire [1:0] mode,
  output reg delayedPending,
  output reg delayedRetry
);
  reg [3:0] tick = 4'h0;
  always @(posedge core_clk) begin
    tick <= tick + 4'h1;
    delayedPending <= #1 mode != 2'h0;
    delayedRetry <= #1 mode == 2'h2 && tick == 4'hf;
  end
endmodule

// ### bench/pcecap_core_tb.sv
/* Bench for the capability block: registers, enable table, lanes, discard.
   Assumes the design under hw/ and inputs driven 1 ns after each edge. */
`timescale 1ns/1ns
module pcecap_core_tb;
  localparam [31:0] IOB = 32'habc00000; // Arbitrary I/O base
  reg core_clk = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0;
  reg [7:0] cfgAddr = 8'h00;
  reg [31:0] cfgWData = 32'h0, ahbData = 32'h0;
  reg [1:0] ahbSize = 2'h0, ahbAddrLow = 2'h0, mode = 2'h0;
  wire [31:0] cfgRData_q, spaceMap_q, pciData_q;
  wire [191:0] barMap_q, barMask_q;
  wire [15:0] burstLimit_q;
  wire [7:0] capPtr_q;
  wire [5:0] barEnable_q, prefetchableFlag_q;
  wire [3:0] pciByteEnN_q;
  wire endianLittle_q, discardTimeoutEnable_q, sizeError_q, delayedDiscard_q;
  wire delayedPending, delayedRetry;
  integer error_cnt = 0, n_compared = 0, cyc = 0, nDisc = 0, e, i, k;
  // Rows: size, address, little-endian enables, big-endian enables
  reg [11:0] rows [0:7] = '{12'h0e7, 12'h1db, 12'h2bd, 12'h37e,
    12'h4c3, 12'h63c, 12'h800, 12'h5ff};
  // Register rows: offset, write data, expected read back
  reg [71:0] regRows [0:7] = '{72'h00ffffffff00400009, 72'h24fff0000ffff00008,
    72'h041234567812300000, 72'h1cabcdefffabcdef00, 72'h20ffffffffabc00003,
    72'h3cffff040000000400, 72'h287ff000007ff00000, 72'h24ff000008ff000008};
  pcecap_core #(.IO_BASE(IOB)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWData(cfgWData),
    .cfgRData_q(cfgRData_q), .capPtr_q(capPtr_q), .endianLittle_q(endianLittle_q),
    .discardTimeoutEnable_q(discardTimeoutEnable_q), .burstLimit_q(burstLimit_q),
    .barEnable_q(barEnable_q), .prefetchableFlag_q(prefetchableFlag_q),
    .barMap_q(barMap_q), .barMask_q(barMask_q), .spaceMap_q(spaceMap_q),
    .ahbSize(ahbSize), .ahbAddrLow(ahbAddrLow), .pciByteEnN_q(pciByteEnN_q),
    .sizeError_q(sizeError_q), .ahbData(ahbData), .pciData_q(pciData_q),
    .delayedPending(delayedPending), .delayedRetry(delayedRetry),
    .delayedDiscard_q(delayedDiscard_q));
  pcecap_agent u_agent (.core_clk(core_clk), .mode(mode), .delayedPending(delayedPending),
    .delayedRetry(delayedRetry));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (delayedDiscard_q === 1'b1) nDisc = nDisc + 1;
    if (cyc == 45000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("mismatch %0s expected %h seen %h", name, exp, got);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      tk(1);
      cfgWrite = 1'b1;
      cfgAddr = a;
      cfgWData = d;
      tk(1);
      cfgWrite = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      tk(1);
      cfgRead = 1'b1;
      cfgAddr = a;
      tk(1);
      cfgRead = 1'b0;
      chk("cfgRData_q", exp, cfgRData_q);
    end
  endtask
  initial begin
    for (e = 0; e < 2; e = e + 1) begin
      wait (reset_n);
      wr(8'h20, e | 2);
      tk(3);
      ahbData = 32'h12345678;
      tk(1);
      chk("pciData_q", e ? 32'h78563412 : 32'h12345678, pciData_q);
      for (i = 0; i < 8; i = i + 1) begin
        {ahbSize, ahbAddrLow} = rows[i][11:8];
        tk(1);
        chk("pciByteEnN_q", e ? rows[i][7:4] : rows[i][3:0], pciByteEnN_q);
        chk("sizeError_q", rows[i][7:0] == 8'hff, sizeError_q);
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      wr(regRows[i][71:64], regRows[i][63:32]);
      rd(regRows[i][71:64], regRows[i][31:0]);
    end
    rd(8'h04, 32'h12000000);
    rd(8'h40, 32'h00000000);
    chk("barEnable_q", 32'h01, barEnable_q);
    chk("prefetchableFlag_q", 32'h01, prefetchableFlag_q);
    chk("barMap_q", 32'h12000000, barMap_q[31:0]);
    chk("barMask_q", 32'h7ff00000, barMask_q[63:32]);
    chk("spaceMap_q", 32'habcdef00, spaceMap_q);
    chk("burstLimit_q", 32'h400, burstLimit_q);
    ahbSize = 2'h3;
    mode = 2'h2;
    tk(300);
    chk("sizeError_q", 1, sizeError_q);
    chk("early discard", 0, nDisc);
    mode = 2'h1;
    k = 0;
    while (delayedDiscard_q !== 1'b1 && k < 33000) begin
      tk(1);
      k = k + 1;
    end
    chk("discard delay", 1, k >= 32766 && k <= 32772);
    tk(1);
    chk("discard count", 1, nDisc);
    wr(8'h3c, 32'h00001234);
    reset_n = 1'b0;
    tk(2);
    reset_n = 1'b1;
    tk(1);
    chk("burstLimit_q after reset", 32'hffff, burstLimit_q);
    chk("endian after reset", 0, {endianLittle_q, discardTimeoutEnable_q});
    chk("capPtr_q after reset", 32'h40, capPtr_q);
    rd(8'h24, 32'h00000000);
    end_sim;
  end
  initial begin
    tk(5);
    reset_n = 1'b1;
    tk(1);
    chk("capPtr_q", 32'h40, capPtr_q);
    chk("burstLimit_q", 32'hffff, burstLimit_q);
    chk("endian and discard", 0, {endianLittle_q, discardTimeoutEnable_q});
  end
endmodule
bind pcecap_core pcecap_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWData(cfgWData),
  .cfgRData_q(cfgRData_q), .capPtr_q(capPtr_q), .endianLittle_q(endianLittle_q),
  .burstLimit_q(burstLimit_q), .ahbSize(ahbSize), .ahbAddrLow(ahbAddrLow),
  .pciByteEnN_q(pciByteEnN_q), .ahbData(ahbData), .pciData_q(pciData_q));
